// ### core/pin_drive_mode_control.sv
// one eight-pin port: drive modes, data, pin state, edge interrupts
// plus two usb-capable pins; registers over apb, one wait state
// assumes pad inputs are synchronous to pclk
//
// Notes on behaviour
// - three-bit drive mode per pin
// - mode 0 analog hi-z reset default
// - mode 1 hi-z, input buffer on
// - modes 2,3 resistive up/down plus strong
// - mode 4 open drain drives low
// - mode 5 open drain drives high
// - mode 6 strong, mode 7 resistive both
// - output from system or data register
// - pin state always; system input gated
// - separate pin state and output registers
// - port form and pin form share bits
// - reset state programmable by user
// - per-pin edge interrupt, one per port
// - no port pin pulls while regulated level used; usb pin pull-up not affected
// - usb pin drive enable gives strong
// - usb pin low strong, high pulled/hi-z
// - usb mode ignores usb drive bits
// - port writes leave usb bits alone
`timescale 1ns/1ns
module pin_drive_mode_control
  import pin_ctl_pkg::*;
#(
  parameter int PINS = NPINS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS-1:0] pad_in,
  input wire logic [PINS-1:0] sys_out,
  input wire logic [1:0] usb_pad_in,
  output logic [PINS-1:0] pad_strong_hi,
  output logic [PINS-1:0] pad_strong_lo,
  output logic [PINS-1:0] pad_res_hi,
  output logic [PINS-1:0] pad_res_lo,
  output logic [PINS-1:0] pad_in_en,
  output logic [PINS-1:0] sys_in,
  output logic [1:0] usb_strong_hi,
  output logic [1:0] usb_strong_lo,
  output logic [1:0] usb_res_hi,
  output logic port_irq
);
  initial
  begin
    if (PINS != NPINS)
      $error("pin_drive_mode_control serves eight pins only");
  end

  ////////////////////////////////////////////////////////////////////////
  // register state

  // port_drive_mode_reg as three planes
  logic [PINS-1:0] dm0_ff, dm1_ff, dm2_ff;
  // port_output_data_reg
  logic [PINS-1:0] dr_ff;
  // pin_state_reg
  logic [PINS-1:0] ps_ff;
  // hw_output_select per pin
  logic [PINS-1:0] hwsel_ff;
  // digital input terminal connect
  logic [PINS-1:0] inen_ff;
  // edge enables and sticky status
  logic [PINS-1:0] rise_ff, fall_ff, stat_ff;
  // user reset image, loaded on the first edge after reset release
  // power-up value only: presetn leaves the image alone
  logic [PINS-1:0] rdm0_ff = 8'h00, rdm1_ff = 8'h00;
  logic [PINS-1:0] rdm2_ff = 8'h00, rdr_ff = 8'h00;
  // restore pulse after reset release
  logic boot_ff;
  // usb mode, regulated level, usb pin bits
  logic usb_mode_ff, reg_hi_ff;
  logic [1:0] usb_de_ff, usb_pu_ff, usb_dr_ff;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  // writes land only at the edge that completes the access phase
  wire wr = psel & penable & pwrite & pready;
  wire rd = psel & penable & ~pwrite;
  wire pin_hit = paddr[11:5] == OFS_PIN_BASE[11:5] && paddr[1:0] == 2'b00;
  wire [2:0] pin_idx = paddr[4:2];
  wire known = pin_hit | (paddr <= OFS_MISC && paddr[1:0] == 2'b00);
  wire [7:0] wb = pwdata[7:0];

  // one-hot write strobe for a port-form offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = a == o;
  endfunction

  wire [PINS-1:0] pin_sel = pin_hit ? (8'h01 << pin_idx) : 8'h00;

  // merge port-form and pin-form writes onto one bit
  function automatic logic [7:0] merge(input logic [7:0] cur,
    input logic port_w, input logic [7:0] sel, input logic bitv,
    input logic pin_w);
    logic [7:0] r;
    r = cur;
    if (port_w)
      r = wb;
    if (pin_w)
      r = (r & ~sel) | (sel & {8{bitv}});
    merge = r;
  endfunction

  wire pw = wr & pin_hit;
  wire [7:0] nxt_dm0 = merge(dm0_ff, wr & hit(paddr, OFS_DM0), pin_sel,
    pwdata[PF_DM_LO], pw);
  wire [7:0] nxt_dm1 = merge(dm1_ff, wr & hit(paddr, OFS_DM1), pin_sel,
    pwdata[PF_DM_LO+1], pw);
  wire [7:0] nxt_dm2 = merge(dm2_ff, wr & hit(paddr, OFS_DM2), pin_sel,
    pwdata[PF_DM_LO+2], pw);
  wire [7:0] nxt_dr = merge(dr_ff, wr & hit(paddr, OFS_DR), pin_sel,
    pwdata[PF_DR], pw);
  wire [7:0] nxt_hwsel = merge(hwsel_ff, wr & hit(paddr, OFS_HWSEL),
    pin_sel, pwdata[PF_HWSEL], pw);
  wire [7:0] nxt_rise = merge(rise_ff, wr & hit(paddr, OFS_IRQ_RISE),
    pin_sel, pwdata[PF_IRQ_R], pw);
  wire [7:0] nxt_fall = merge(fall_ff, wr & hit(paddr, OFS_IRQ_FALL),
    pin_sel, pwdata[PF_IRQ_F], pw);

  ////////////////////////////////////////////////////////////////////////
  // edge detection

  // pin state follows pad every cycle
  wire [PINS-1:0] nxt_ps = pad_in;
  wire [PINS-1:0] edge_ev = (pad_in & ~ps_ff & rise_ff)
    | (~pad_in & ps_ff & fall_ff);
  // status write-one-to-clear; set wins over clear
  wire [PINS-1:0] stat_clr = (wr & hit(paddr, OFS_IRQ_STAT)) ? wb : 8'h00;
  wire [PINS-1:0] nxt_stat = (stat_ff & ~stat_clr) | edge_ev;

  ////////////////////////////////////////////////////////////////////////
  // registers

  // control bits update at the write edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dm0_ff <= 8'h00;
      dm1_ff <= 8'h00;
      dm2_ff <= 8'h00;
      dr_ff <= 8'h00;
      hwsel_ff <= 8'h00;
      rise_ff <= 8'h00;
      fall_ff <= 8'h00;
    end
    else if (boot_ff)
    begin
      dm0_ff <= rdm0_ff;
      dm1_ff <= rdm1_ff;
      dm2_ff <= rdm2_ff;
      dr_ff <= rdr_ff;
    end
    else
    begin
      dm0_ff <= nxt_dm0;
      dm1_ff <= nxt_dm1;
      dm2_ff <= nxt_dm2;
      dr_ff <= nxt_dr;
      hwsel_ff <= nxt_hwsel;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  // reset image survives presetn so software picks the reset state
  // limitation: only power-up returns it to analog hi-z
  always_ff @(posedge pclk)
  begin
    if (wr && hit(paddr, OFS_RST_DM0))
      rdm0_ff <= wb;
    if (wr && hit(paddr, OFS_RST_DM1))
      rdm1_ff <= wb;
    if (wr && hit(paddr, OFS_RST_DM2))
      rdm2_ff <= wb;
    if (wr && hit(paddr, OFS_RST_DR))
      rdr_ff <= wb;
  end

  // restore pulse on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boot_ff <= 1'b1;
    else
      boot_ff <= 1'b0;
  end

  // input side, status, misc
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ps_ff <= 8'h00;
      stat_ff <= 8'h00;
      inen_ff <= 8'h00;
      usb_mode_ff <= 1'b0;
      reg_hi_ff <= 1'b0;
      usb_de_ff <= 2'h0;
      usb_pu_ff <= 2'h0;
      usb_dr_ff <= 2'h0;
    end
    else
    begin
      ps_ff <= nxt_ps;
      stat_ff <= nxt_stat;
      if (wr && hit(paddr, OFS_INEN))
        inen_ff <= wb;
      // usb bits only via misc register
      if (wr && hit(paddr, OFS_MISC))
      begin
        usb_mode_ff <= pwdata[MISC_USB_MODE];
        reg_hi_ff <= pwdata[MISC_REG_HI];
        usb_de_ff <= pwdata[MISC_USB0+1:MISC_USB0];
        usb_pu_ff <= pwdata[MISC_USB0+3:MISC_USB0+2];
        usb_dr_ff <= pwdata[MISC_USB0+5:MISC_USB0+4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux

  // pin state read apart from data
  wire [7:0] port_rd =
    hit(paddr, OFS_DM0) ? dm0_ff :
    hit(paddr, OFS_DM1) ? dm1_ff :
    hit(paddr, OFS_DM2) ? dm2_ff :
    hit(paddr, OFS_DR) ? dr_ff :
    hit(paddr, OFS_PS) ? ps_ff :
    hit(paddr, OFS_HWSEL) ? hwsel_ff :
    hit(paddr, OFS_INEN) ? inen_ff :
    hit(paddr, OFS_IRQ_RISE) ? rise_ff :
    hit(paddr, OFS_IRQ_FALL) ? fall_ff :
    hit(paddr, OFS_IRQ_STAT) ? stat_ff :
    hit(paddr, OFS_RST_DM0) ? rdm0_ff :
    hit(paddr, OFS_RST_DM1) ? rdm1_ff :
    hit(paddr, OFS_RST_DM2) ? rdm2_ff :
    hit(paddr, OFS_RST_DR) ? rdr_ff : 8'h00;
  // pin form gathers one pin's bits
  wire [7:0] pin_rd = {fall_ff[pin_idx], rise_ff[pin_idx],
    hwsel_ff[pin_idx], dm2_ff[pin_idx], dm1_ff[pin_idx], dm0_ff[pin_idx],
    ps_ff[pin_idx], dr_ff[pin_idx]};
  wire [31:0] misc_rd = {16'h0000, usb_pad_in, usb_dr_ff, usb_pu_ff,
    usb_de_ff, 6'h00, reg_hi_ff, usb_mode_ff};
  wire [31:0] nxt_prdata = !rd ? RDATA_ZERO :
    pin_hit ? {24'h000000, pin_rd} :
    hit(paddr, OFS_MISC) ? misc_rd : {24'h000000, port_rd};

  // apb answer registered: ready one cycle into access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~known;
      prdata <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad control

  wire [PINS-1:0] out_val = (hwsel_ff & sys_out) | (~hwsel_ff & dr_ff);
  logic [PINS-1:0] sh, sl, rh, rl, ie;

  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_pin
      drive_decode u_dec (
        .drive_mode_bits({dm2_ff[g], dm1_ff[g], dm0_ff[g]}),
        .data(out_val[g]),
        .reg_hi(reg_hi_ff),
        .strong_hi(sh[g]),
        .strong_lo(sl[g]),
        .res_hi(rh[g]),
        .res_lo(rl[g]),
        .in_en(ie[g])
      );
    end
    for (g = 0; g < 2; g++)
    begin : g_usb
      logic ush, usl, urh;
      usb_drive u_usb (
        .usb_pin_drive_enable(usb_de_ff[g]),
        .usb_pin_pullup_enable(usb_pu_ff[g]),
        .usb_pin_output_data(usb_dr_ff[g]),
        .usb_mode(usb_mode_ff),
        .strong_hi(ush),
        .strong_lo(usl),
        .res_hi(urh)
      );
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          usb_strong_hi[g] <= 1'b0;
          usb_strong_lo[g] <= 1'b0;
          usb_res_hi[g] <= 1'b0;
        end
        else
        begin
          usb_strong_hi[g] <= ush;
          usb_strong_lo[g] <= usl;
          usb_res_hi[g] <= urh;
        end
      end
    end
  endgenerate

  // pad outputs registered so each comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_strong_hi <= 8'h00;
      pad_strong_lo <= 8'h00;
      pad_res_hi <= 8'h00;
      pad_res_lo <= 8'h00;
      pad_in_en <= 8'h00;
      sys_in <= 8'h00;
      port_irq <= 1'b0;
    end
    else
    begin
      pad_strong_hi <= sh;
      pad_strong_lo <= sl;
      pad_res_hi <= rh;
      pad_res_lo <= rl;
      pad_in_en <= ie;
      sys_in <= ps_ff & ie & inen_ff;
      port_irq <= |nxt_stat;
    end
  end
endmodule

// ### core/pin_ctl_pkg.sv
// constants for the pin drive mode control block
// assumes one apb slave, 32-bit data, one port of eight pins
package pin_ctl_pkg;
  localparam int NPINS = 8;
  localparam int DM_W = 3;
  localparam int AW = 12;
  // port-wide register byte offsets
  localparam logic [11:0] OFS_DM0 = 12'h000;
  localparam logic [11:0] OFS_DM1 = 12'h004;
  localparam logic [11:0] OFS_DM2 = 12'h008;
  localparam logic [11:0] OFS_DR = 12'h00C;
  localparam logic [11:0] OFS_PS = 12'h010;
  localparam logic [11:0] OFS_HWSEL = 12'h014;
  localparam logic [11:0] OFS_INEN = 12'h018;
  localparam logic [11:0] OFS_IRQ_RISE = 12'h01C;
  localparam logic [11:0] OFS_IRQ_FALL = 12'h020;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h024;
  localparam logic [11:0] OFS_RST_DM0 = 12'h028;
  localparam logic [11:0] OFS_RST_DM1 = 12'h02C;
  localparam logic [11:0] OFS_RST_DM2 = 12'h030;
  localparam logic [11:0] OFS_RST_DR = 12'h034;
  localparam logic [11:0] OFS_MISC = 12'h038;
  localparam logic [11:0] OFS_PIN_BASE = 12'h040;
  // misc register fields
  localparam int MISC_USB_MODE = 0;
  localparam int MISC_REG_HI = 1;
  localparam int MISC_USB0 = 8;
  // pin-form register fields
  localparam int PF_DR = 0;
  localparam int PF_PS = 1;
  localparam int PF_DM_LO = 2;
  localparam int PF_HWSEL = 5;
  localparam int PF_IRQ_R = 6;
  localparam int PF_IRQ_F = 7;
  // reset values
  localparam logic [2:0] DM_RESET = 3'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // drive mode codes
  localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
  localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
  localparam logic [2:0] DM_RES_UP = 3'h2;
  localparam logic [2:0] DM_RES_DOWN = 3'h3;
  localparam logic [2:0] DM_OD_LOW = 3'h4;
  localparam logic [2:0] DM_OD_HIGH = 3'h5;
  localparam logic [2:0] DM_STRONG = 3'h6;
  localparam logic [2:0] DM_RES_BOTH = 3'h7;
endpackage

// ### core/drive_decode.sv
// one pin's drive decoder: mode and data to pad controls
// assumes the caller registers the outputs
`timescale 1ns/1ns
module drive_decode
  import pin_ctl_pkg::*;
(
  input wire logic [2:0] drive_mode_bits,
  input wire logic data,
  input wire logic reg_hi,
  output logic strong_hi,
  output logic strong_lo,
  output logic res_hi,
  output logic res_lo,
  output logic in_en
);
  // resistive pulls removed while regulated output level is in use
  logic rh;
  logic rl;
  always_comb
  begin
    strong_hi = 1'b0;
    strong_lo = 1'b0;
    rh = 1'b0;
    rl = 1'b0;
    in_en = 1'b1;
    unique case (drive_mode_bits)
      DM_HIZ_ANALOG: in_en = 1'b0;
      DM_HIZ_DIGITAL: in_en = 1'b1;
      DM_RES_UP:
      begin
        rh = data;
        strong_lo = ~data;
      end
      DM_RES_DOWN:
      begin
        strong_hi = data;
        rl = ~data;
      end
      DM_OD_LOW: strong_lo = ~data;
      DM_OD_HIGH: strong_hi = data;
      DM_STRONG:
      begin
        strong_hi = data;
        strong_lo = ~data;
      end
      DM_RES_BOTH:
      begin
        rh = data;
        rl = ~data;
      end
    endcase
  end
  assign res_hi = rh & ~reg_hi;
  assign res_lo = rl & ~reg_hi;
endmodule

// ### core/usb_drive.sv
// drive decoder for one usb-capable pin in i/o mode
// assumes usb mode pad control comes from the usb core
`timescale 1ns/1ns
module usb_drive
(
  input wire logic usb_pin_drive_enable,
  input wire logic usb_pin_pullup_enable,
  input wire logic usb_pin_output_data,
  input wire logic usb_mode,
  output logic strong_hi,
  output logic strong_lo,
  output logic res_hi
);
  wire io_mode = ~usb_mode;
  assign strong_hi = io_mode & usb_pin_drive_enable & usb_pin_output_data;
  assign strong_lo = io_mode & ~usb_pin_output_data;
  assign res_hi = io_mode & ~usb_pin_drive_enable & usb_pin_pullup_enable
    & usb_pin_output_data;
endmodule

// ### tb/pin_ctl_asserts.sv
// checker: apb timing and pad driver sanity of the pin drive port
// assumes it is bound into pin_drive_mode_control, one clock domain
`timescale 1ns/1ns
module pin_ctl_asserts
  import pin_ctl_pkg::*;
#(
  parameter int PINS = NPINS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PINS-1:0] pad_strong_hi,
  input wire logic [PINS-1:0] pad_strong_lo,
  input wire logic [PINS-1:0] pad_res_hi,
  input wire logic [PINS-1:0] pad_res_lo,
  input wire logic [1:0] usb_strong_hi,
  input wire logic [1:0] usb_strong_lo,
  input wire logic [1:0] usb_res_hi
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // port registers plus one word per pin
  wire logic mapped;
  assign mapped = paddr[1:0] == 2'h0 && (paddr <= OFS_MISC ||
    (paddr >= OFS_PIN_BASE && paddr < OFS_PIN_BASE + 12'(4 * PINS)));
  // first cycle of an access phase
  sequence acc_start;
    psel && penable && !$past(penable);
  endsequence
  ready_one_a: assert property (acc_start |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (acc_start ##0 !mapped |=>
    pslverr && (pwrite || prdata == RDATA_ZERO))
    else $error("unmapped access accepted");
  mapped_ok_a: assert property (acc_start ##0 mapped |=> !pslverr)
    else $error("mapped access refused");
  // a pad is never pushed both ways at once
  pad_clash_a: assert property ((pad_strong_hi & (pad_strong_lo |
    pad_res_lo)) == '0 && (pad_res_hi & (pad_res_lo | pad_strong_lo)) == '0)
    else $error("pad driven both ways");
  usb_clash_a: assert property ((usb_strong_hi & usb_strong_lo) == '0 &&
    (usb_res_hi & (usb_strong_hi | usb_strong_lo)) == '0)
    else $error("usb pad driven both ways");
endmodule
bind pin_drive_mode_control pin_ctl_asserts #(.PINS(PINS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pad_strong_hi(pad_strong_hi),
  .pad_strong_lo(pad_strong_lo), .pad_res_hi(pad_res_hi),
  .pad_res_lo(pad_res_lo), .usb_strong_hi(usb_strong_hi),
  .usb_strong_lo(usb_strong_lo), .usb_res_hi(usb_res_hi));

// ### tb/pin_load.sv
// external load on the port pads: outside drive, pulls, floating
// assumes pad controls are active-high levels from the port
`timescale 1ns/1ns
module pin_load
(
  input wire logic pclk,
  input wire logic [7:0] strong_hi,
  input wire logic [7:0] strong_lo,
  input wire logic [7:0] res_hi,
  input wire logic [7:0] res_lo,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] level
);
  // an undriven pad wanders, so it never reads as steady
  logic [7:0] flt_ff = 8'h55;
  always_ff @(posedge pclk)
    flt_ff <= ~flt_ff;
  // strong drive wins, outside drive beats a resistive pull
  always_comb
    for (int i = 0; i < 8; i++)
      if (strong_hi[i] | strong_lo[i])
        level[i] = strong_hi[i];
      else if (ext_en[i])
        level[i] = ext_val[i];
      else if (res_hi[i] | res_lo[i])
        level[i] = res_hi[i];
      else
        level[i] = flt_ff[i];
endmodule

// ### tb/tb.sv
// testbench: pin drive port over apb with an external load
// assumes one wait state answers and registered pad controls
`timescale 1ns/1ns
module tb
  import pin_ctl_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lfsr;
  logic [7:0] pad_in, sys_out, pad_strong_hi, pad_strong_lo, v, dr;
  logic [7:0] pad_res_hi, pad_res_lo, pad_in_en, sys_in, ext_en, ext_val;
  logic [1:0] usb_pad_in, usb_strong_hi, usb_strong_lo, usb_res_hi;
  logic port_irq, err, rhi;
  logic [2:0] dm [8]; // expected mode of each pin
  logic [5:0] usb_a;
  logic [2:0] e0, e1;
  logic [7:0] ev [5] = '{8'h04, 8'h0D, 8'h0F, 8'h05, 8'h00};
  logic [7:0] es [5] = '{8'h00, 8'h09, 8'h00, 8'h0A, 8'h00};
  int num_errors, num_checks, p;
  pin_drive_mode_control u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .sys_out(sys_out), .usb_pad_in(usb_pad_in),
    .pad_strong_hi(pad_strong_hi), .pad_strong_lo(pad_strong_lo),
    .pad_res_hi(pad_res_hi), .pad_res_lo(pad_res_lo),
    .pad_in_en(pad_in_en), .sys_in(sys_in), .usb_strong_hi(usb_strong_hi),
    .usb_strong_lo(usb_strong_lo), .usb_res_hi(usb_res_hi),
    .port_irq(port_irq));
  pin_load u_load (.pclk(pclk), .strong_hi(pad_strong_hi),
    .strong_lo(pad_strong_lo), .res_hi(pad_res_hi), .res_lo(pad_res_lo),
    .ext_en(ext_en), .ext_val(ext_val), .level(pad_in));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  // {strong hi, strong lo, res hi, res lo}; pulls drop at regulated level
  function automatic logic [3:0] drv(input logic [2:0] m, input logic d);
    logic [3:0] x;
    case (m)
      3'h2: x = d ? 4'h2 : 4'h4;
      3'h3: x = d ? 4'h8 : 4'h1;
      3'h4: x = d ? 4'h0 : 4'h4;
      3'h5: x = d ? 4'h8 : 4'h0;
      3'h6: x = d ? 4'h8 : 4'h4;
      3'h7: x = d ? 4'h2 : 4'h1;
      default: x = 4'h0;
    endcase
    return rhi ? {x[3:2], 2'h0} : x;
  endfunction
  // usb pad {strong hi, strong lo, res hi}
  function automatic logic [2:0] usbx(input logic pe, de, d);
    if (!d)
      return 3'h2;
    return de ? 3'h4 : {2'h0, pe};
  endfunction
  task automatic chk(input string nm, input logic [39:0] g, x);
    num_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 9);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      give_verdict();
    end
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), {err, rd}, {1'b0, x});
  endtask
  // pads follow the registers one edge after the write lands
  task automatic chk_pads();
    @(posedge pclk);
    for (int i = 0; i < 8; i++)
      chk("pad", {pad_strong_hi[i], pad_strong_lo[i], pad_res_hi[i],
        pad_res_lo[i], pad_in_en[i]}, {drv(dm[i], dr[i]), dm[i] != 3'h0});
  endtask
  ////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, rhi} = 5'h00;
    {paddr, pwdata, sys_out, ext_en, ext_val, dr} = '0;
    usb_pad_in = 2'h0;
    lfsr = 32'h00011E27;
    for (int i = 0; i < 8; i++)
      dm[i] = DM_RESET;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_pads();
    rchk(OFS_DM2, 32'h0);
    $display("reset test done");
    // every mode and data value on random pins, then regulated level
    for (int r = 0; r < 2; r++)
    begin
      rhi = r[0];
      apb(1'b1, OFS_MISC, {30'h0, rhi, 1'b0});
      for (int k = 0; k < 16; k++)
      begin
        p = rnd() % 8;
        dm[p] = k[3:1];
        dr[p] = k[0];
        apb(1'b1, OFS_PIN_BASE + 12'(4 * p), {27'h0, dm[p], 1'b0, dr[p]});
        chk_pads();
      end
    end
    for (int k = 0; k < 3; k++)
      rchk(OFS_DM0 + 12'(4 * k), {24'h0, dm[7][k], dm[6][k], dm[5][k],
        dm[4][k], dm[3][k], dm[2][k], dm[1][k], dm[0][k]});
    v = rnd();
    apb(1'b1, OFS_DM1, {24'h0, v});
    for (int i = 0; i < 8; i++)
      dm[i][1] = v[i];
    chk_pads();
    apb(1'b0, OFS_PIN_BASE + 12'(4 * p), 32'h0);
    chk("pin form", {rd[4:2], rd[0]}, {dm[p], dr[p]});
    $display("mode test done");
    // strong drive on all pins, output taken from the system
    apb(1'b1, OFS_DM0, 32'h0);
    apb(1'b1, OFS_DM2, 32'hFF);
    apb(1'b1, OFS_DM1, 32'hFF);
    apb(1'b1, OFS_HWSEL, 32'hFF);
    repeat (4)
    begin
      sys_out <= rnd();
      repeat (2) @(posedge pclk);
      chk("hw out", {pad_strong_hi, pad_strong_lo}, {sys_out, ~sys_out});
    end
    apb(1'b1, OFS_HWSEL, 32'h0);
    for (int i = 0; i < 8; i++)
      dm[i] = DM_STRONG;
    chk_pads();
    // hi-z digital, outside drive; pin 0 analog
    apb(1'b1, OFS_DM2, 32'h0);
    apb(1'b1, OFS_DM1, 32'h0);
    apb(1'b1, OFS_DM0, 32'hFE);
    v = rnd();
    ext_en <= 8'hFF;
    ext_val <= v;
    apb(1'b1, OFS_DR, {24'h0, ~v});
    rchk(OFS_PS, {24'h0, v});
    apb(1'b1, OFS_INEN, 32'hFF);
    @(posedge pclk);
    chk("sys in", sys_in, v & 8'hFE);
    apb(1'b1, OFS_INEN, 32'h0);
    @(posedge pclk);
    chk("sys in", sys_in, 8'h00);
    $display("input test done");
    // edges: pin 0 rising, pin 1 falling, pin 3 both
    apb(1'b1, OFS_DM0, 32'hFF);
    ext_val <= 8'h00;
    apb(1'b1, OFS_IRQ_RISE, 32'h09);
    apb(1'b1, OFS_IRQ_FALL, 32'h0A);
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, OFS_IRQ_STAT, 32'hFF);
      chk("irq clear", port_irq, 1'b0);
      ext_val <= ev[k];
      repeat (3) @(posedge pclk);
      chk("irq", port_irq, |es[k]);
      rchk(OFS_IRQ_STAT, {24'h0, es[k]});
    end
    $display("edge test done");
    // usb pins in i/o mode; pin 1 gets the inverse data
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, OFS_MISC, {18'h0, ~k[0], k[0], {2{k[2]}}, {2{k[1]}}, 8'h00});
      e0 = usbx(k[2], k[1], k[0]);
      e1 = usbx(k[2], k[1], ~k[0]);
      @(posedge pclk);
      chk("usb", {usb_strong_hi, usb_strong_lo, usb_res_hi}, {e1[2], e0[2],
        e1[1], e0[1], e1[0], e0[0]});
    end
    apb(1'b1, OFS_MISC, 32'h1);
    @(posedge pclk);
    usb_a = {usb_strong_hi, usb_strong_lo, usb_res_hi};
    apb(1'b1, OFS_MISC, 32'h3F01);
    @(posedge pclk);
    chk("usb mode", {usb_strong_hi, usb_strong_lo, usb_res_hi}, usb_a);
    apb(1'b1, OFS_MISC, 32'h2300);
    apb(1'b1, OFS_DM0, 32'h0);
    apb(1'b1, OFS_DR, 32'hFF);
    rchk(OFS_MISC, 32'h2300);
    chk("usb kept", {usb_strong_hi, usb_strong_lo, usb_res_hi}, 6'h24);
    $display("usb test done");
    // user reset image survives a mid-run reset and is applied after it
    v = rnd();
    apb(1'b1, OFS_RST_DM1, 32'hFF);
    apb(1'b1, OFS_RST_DM2, 32'hFF);
    apb(1'b1, OFS_RST_DR, {24'h0, v});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rhi = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      dm[i] = DM_STRONG;
      dr[i] = v[i];
    end
    chk_pads();
    rchk(OFS_RST_DR, {24'h0, v});
    $display("reset image test done");
    apb(1'b0, 12'h03C, 32'h0);
    chk("unmapped rd", {err, rd}, {1'b1, RDATA_ZERO});
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    chk("unmapped wr", err, 1'b1);
    $display("refusal test done");
    give_verdict();
  end
endmodule
